// ===== hdl/sir_pkg.sv
package sir_pkg;

	localparam int SIR_NUM_SRC = 8;
	localparam int SIR_ADDR_W = 8;
	localparam int SIR_DATA_W = 8;

	// Register offsets
	localparam logic [7:0] SIR_OFS_PIN_CONFIG = 8'h28;
	localparam logic [7:0] SIR_OFS_SOURCE_ENABLE = 8'h29;
	localparam logic [7:0] SIR_OFS_SOURCE_ROUTE = 8'h2a;
	localparam logic [7:0] SIR_OFS_IRQ_SOURCE = 8'h40;
	localparam logic [7:0] SIR_OFS_IRQ_STATUS = 8'h41;
	localparam logic [7:0] SIR_OFS_IRQ_MASK = 8'h42;
	localparam logic [7:0] SIR_OFS_IRQ_MODE = 8'h43;

	// Field positions in irq_pin_config
	localparam int SIR_BIT_PIN_A_POLARITY = 5;
	localparam int SIR_BIT_PIN_A_DRIVE = 4;
	localparam int SIR_BIT_PIN_B_POLARITY = 1;
	localparam int SIR_BIT_PIN_B_DRIVE = 0;
	localparam logic [7:0] SIR_PIN_CONFIG_WMASK = 8'h33;

	// Field position in irq_mode
	localparam int SIR_BIT_RAW_MODE = 0;
	localparam logic [7:0] SIR_IRQ_MODE_WMASK = 8'h01;

	// Values after reset, and the read value of an unmapped offset
	localparam logic [7:0] SIR_RST_PIN_CONFIG = 8'h00;
	localparam logic [7:0] SIR_RST_SOURCE_ENABLE = 8'h00;
	localparam logic [7:0] SIR_RST_SOURCE_ROUTE = 8'h00;
	localparam logic [7:0] SIR_RST_IRQ_STATUS = 8'h00;
	localparam logic [7:0] SIR_RST_IRQ_MASK = 8'h00;
	localparam logic [7:0] SIR_RST_IRQ_MODE = 8'h00;
	localparam logic [7:0] SIR_RST_RDATA = 8'h00;
	localparam logic [7:0] SIR_UNMAPPED_RDATA = 8'h00;
	localparam logic SIR_RST_IRQ = 1'b0;
	// Idle level of an active-low push-pull pin
	localparam logic SIR_RST_PIN_LEVEL = 1'b1;
	localparam logic SIR_RST_PIN_OE = 1'b1;

	// Bit order of the source flags, enables, routes and status
	typedef struct packed {
		logic data_ready;
		logic sample_buffer;
		logic pressure_window;
		logic temp_window;
		logic pressure_threshold;
		logic temp_threshold;
		logic pressure_change;
		logic temp_change;
	} sir_src_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} sir_bus_req_s;

	typedef struct packed {
		logic polarity;
		logic drive_select;
	} sir_pin_cfg_s;

	typedef struct packed {
		logic out;
		logic oe;
	} sir_pin_s;

endpackage

// ===== hdl/sir_pin_driver.sv
`timescale 1ns/1ns
module sir_pin_driver (
	input wire logic clk,
	input wire logic rst,
	input wire logic active,
	input wire sir_pkg::sir_pin_cfg_s cfg,
	output sir_pkg::sir_pin_s pin
);
	import sir_pkg::*;

	typedef struct packed {
		logic level;
		logic oe;
	} sir_drv_state_s;

	sir_drv_state_s state_reg;
	sir_drv_state_s state_next;

	always_comb begin
		state_next = state_reg;
		// Polarity 0 signals an asserted line as a low level
		if (cfg.polarity) begin
			state_next.level = active;
		end else begin
			state_next.level = ~active;
		end
		// Open drain only pulls low; the shared line floats high otherwise
		if (cfg.drive_select) begin
			state_next.oe = ~state_next.level;
		end else begin
			state_next.oe = 1'b1;
		end
	end

	// Reset shows the idle level of an active-low push-pull pin
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= '{level: SIR_RST_PIN_LEVEL, oe: SIR_RST_PIN_OE};
		end else begin
			state_reg <= state_next;
		end
	end

	assign pin.out = state_reg.level;
	assign pin.oe = state_reg.oe;

endmodule // sir_pin_driver

// ===== hdl/sir_router.sv
// Notes on behaviour
// RL1 - Pin A polarity: 0 (reset) asserts low, 1 asserts high.
// RL2 - Pin A drive: 0 (reset) push-pull with pull-up, 1 open-drain.
// RL3 - Pin B polarity: 0 (reset) asserts low, 1 asserts high.
// RL4 - Pin B drive: 0 (reset) push-pull with pull-up, 1 open-drain.
// RL5 - A source flag reaches either pin only while its enable is set.
// RL6 - Data-ready enable resets to 0; 0 blocks, 1 passes.
// RL7 - Sample-buffer enable resets to 0; 0 blocks, 1 passes.
// RL8 - Pressure and temperature window enables, separate, reset to 0.
// RL9 - Pressure and temperature threshold enables, separate, reset to 0.
// RL10 - Pressure and temperature change enables, separate, reset to 0.
// RL11 - Per-source route bit resets 0; 0 to pin B, 1 to pin A.
// RL12 - Each pin asserts on the OR of enabled sources routed to it.
// RL13 - Host reads the source register to find which sources fired.
// RL14 - Raw output mode suppresses every interrupt source.
// RL15 - A pin deasserts once no enabled routed source remains active.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
module sir_router (
	input wire logic clk,
	input wire logic rst,
	input wire sir_pkg::sir_bus_req_s req,
	output logic [7:0] rdata,
	input wire sir_pkg::sir_src_s src_flags,
	output sir_pkg::sir_pin_s irq_pin_a,
	output sir_pkg::sir_pin_s irq_pin_b,
	output logic irq
);
	import sir_pkg::*;

	typedef struct packed {
		logic [7:0] pin_config;
		sir_src_s enable;
		sir_src_s route;
		logic [7:0] mode;
		sir_src_s status;
		sir_src_s mask;
		logic [7:0] rdata;
		logic irq;
	} sir_router_state_s;

	sir_router_state_s state_reg;
	sir_router_state_s state_next;

	logic [SIR_NUM_SRC-1:0] gated;
	logic [SIR_NUM_SRC-1:0] to_pin_a;
	logic [SIR_NUM_SRC-1:0] to_pin_b;
	logic raw_mode;
	logic active_a;
	logic active_b;
	logic [7:0] status_clear;
	sir_pin_cfg_s cfg_a;
	sir_pin_cfg_s cfg_b;

	// Raw mode blocks every source before the enables even matter
	assign raw_mode = state_reg.mode[SIR_BIT_RAW_MODE]; // RL14

	genvar i;
	generate
		for (i = 0; i < SIR_NUM_SRC; i++) begin : g_src
			// Enable gates the flag ahead of routing
			assign gated[i] = src_flags[i] & state_reg.enable[i] &
				~raw_mode; // RL5 RL14
			assign to_pin_a[i] = gated[i] & state_reg.route[i]; // RL11
			assign to_pin_b[i] = gated[i] & ~state_reg.route[i]; // RL11
		end
	endgenerate

	// Plain OR, so the pin falls as soon as the last source goes
	assign active_a = |to_pin_a; // RL12 RL15
	assign active_b = |to_pin_b; // RL12 RL15

	assign cfg_a.polarity = state_reg.pin_config[SIR_BIT_PIN_A_POLARITY]; // RL1
	assign cfg_a.drive_select = state_reg.pin_config[SIR_BIT_PIN_A_DRIVE]; // RL2
	assign cfg_b.polarity = state_reg.pin_config[SIR_BIT_PIN_B_POLARITY]; // RL3
	assign cfg_b.drive_select = state_reg.pin_config[SIR_BIT_PIN_B_DRIVE]; // RL4

	always_comb begin
		if (req.wr && req.addr == SIR_OFS_IRQ_STATUS) begin
			status_clear = req.wdata;
		end else begin
			status_clear = 8'h00;
		end
	end

	always_comb begin
		state_next = state_reg;
		state_next.rdata = SIR_RST_RDATA;
		if (req.rd) begin
			case (req.addr)
				SIR_OFS_PIN_CONFIG: begin
					state_next.rdata = state_reg.pin_config;
				end
				SIR_OFS_SOURCE_ENABLE: begin
					state_next.rdata = state_reg.enable;
				end
				SIR_OFS_SOURCE_ROUTE: begin
					state_next.rdata = state_reg.route;
				end
				SIR_OFS_IRQ_SOURCE: begin
					// Live view of what is holding the pins
					state_next.rdata = gated; // RL13
				end
				SIR_OFS_IRQ_STATUS: begin
					state_next.rdata = state_reg.status;
				end
				SIR_OFS_IRQ_MASK: begin
					state_next.rdata = state_reg.mask;
				end
				SIR_OFS_IRQ_MODE: begin
					state_next.rdata = state_reg.mode;
				end
				default: begin
					state_next.rdata = SIR_UNMAPPED_RDATA;
				end
			endcase
		end
		if (req.wr) begin
			case (req.addr)
				SIR_OFS_PIN_CONFIG: begin
					state_next.pin_config = req.wdata &
						SIR_PIN_CONFIG_WMASK; // RL1 RL2 RL3 RL4
				end
				SIR_OFS_SOURCE_ENABLE: begin
					state_next.enable = req.wdata; // RL6 RL7 RL8 RL9 RL10
				end
				SIR_OFS_SOURCE_ROUTE: begin
					state_next.route = req.wdata; // RL11
				end
				SIR_OFS_IRQ_MASK: begin
					state_next.mask = req.wdata;
				end
				SIR_OFS_IRQ_MODE: begin
					state_next.mode = req.wdata & SIR_IRQ_MODE_WMASK; // RL14
				end
				default: begin
				end
			endcase
		end
		// A flag present in the clearing cycle stays set
		state_next.status = (state_reg.status & ~status_clear) | gated;
		state_next.irq = |(state_next.status & state_next.mask);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg.pin_config <= SIR_RST_PIN_CONFIG; // RL1 RL2 RL3 RL4
			state_reg.enable <= SIR_RST_SOURCE_ENABLE; // RL6 RL7 RL8 RL9 RL10
			state_reg.route <= SIR_RST_SOURCE_ROUTE; // RL11
			state_reg.mode <= SIR_RST_IRQ_MODE;
			state_reg.status <= SIR_RST_IRQ_STATUS;
			state_reg.mask <= SIR_RST_IRQ_MASK;
			state_reg.rdata <= SIR_RST_RDATA;
			state_reg.irq <= SIR_RST_IRQ;
		end else begin
			state_reg <= state_next;
		end
	end

	sir_pin_driver u_pin_a (
		.clk(clk),
		.rst(rst),
		.active(active_a),
		.cfg(cfg_a),
		.pin(irq_pin_a)
	);

	sir_pin_driver u_pin_b (
		.clk(clk),
		.rst(rst),
		.active(active_b),
		.cfg(cfg_b),
		.pin(irq_pin_b)
	);

	assign rdata = state_reg.rdata;
	assign irq = state_reg.irq;

endmodule // sir_router

// ===== bench/sir_router_asserts.sv
`timescale 1ns/1ns
module sir_router_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire sir_pkg::sir_bus_req_s req,
	input wire logic [7:0] rdata,
	input wire sir_pkg::sir_src_s src_flags,
	input wire sir_pkg::sir_pin_s irq_pin_a,
	input wire sir_pkg::sir_pin_s irq_pin_b,
	input wire logic irq
);
	import sir_pkg::*;
	logic [7:0] cfg_q, en_q, rt_q, md_q;
	logic act_a, act_b;
	// Shadow of the settings as software last wrote them
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{cfg_q, en_q, rt_q, md_q} <= '0;
		end else if (req.wr) begin
			case (req.addr)
				SIR_OFS_PIN_CONFIG: cfg_q <= req.wdata & SIR_PIN_CONFIG_WMASK;
				SIR_OFS_SOURCE_ENABLE: en_q <= req.wdata;
				SIR_OFS_SOURCE_ROUTE: rt_q <= req.wdata;
				SIR_OFS_IRQ_MODE: md_q <= req.wdata & SIR_IRQ_MODE_WMASK;
				default: ;
			endcase
		end
	end
	assign act_a = |(src_flags & en_q & rt_q) && !md_q[0];
	assign act_b = |(src_flags & en_q & ~rt_q) && !md_q[0];
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_pin_a_level: assert property (
		irq_pin_a.out == ($past(cfg_q[5]) ~^ $past(act_a)))
		else $error("pin a level wrong");
	a_pin_b_level: assert property (
		irq_pin_b.out == ($past(cfg_q[1]) ~^ $past(act_b)))
		else $error("pin b level wrong");
	a_pin_a_drive: assert property (
		irq_pin_a.oe == (!$past(cfg_q[4]) || !irq_pin_a.out))
		else $error("pin a enable wrong");
	a_pin_b_drive: assert property (
		irq_pin_b.oe == (!$past(cfg_q[0]) || !irq_pin_b.out))
		else $error("pin b enable wrong");
	a_raw_pins_idle: assert property ($past(md_q[0]) |->
		irq_pin_a.out != $past(cfg_q[5]) && irq_pin_b.out != $past(cfg_q[1]))
		else $error("raw mode pin asserted");
	a_enable_readback: assert property ($past(req.rd) &&
		$past(req.addr) == SIR_OFS_SOURCE_ENABLE |-> rdata == $past(en_q))
		else $error("enable readback wrong");
	a_route_readback: assert property ($past(req.rd) &&
		$past(req.addr) == SIR_OFS_SOURCE_ROUTE |-> rdata == $past(rt_q))
		else $error("route readback wrong");
	a_config_readback: assert property ($past(req.rd) &&
		$past(req.addr) == SIR_OFS_PIN_CONFIG |-> rdata == $past(cfg_q))
		else $error("config readback wrong");
	c_pin_a: cover property (irq_pin_a.out == cfg_q[5]);
	c_pin_b: cover property (irq_pin_b.out == cfg_q[1]);
	c_irq: cover property (irq);
endmodule // sir_router_asserts

bind sir_router sir_router_asserts chk (.clk(clk), .rst(rst), .req(req),
	.rdata(rdata), .src_flags(src_flags), .irq_pin_a(irq_pin_a),
	.irq_pin_b(irq_pin_b), .irq(irq));

// ===== bench/sir_host_model.sv
`timescale 1ns/1ns
module sir_host_model (
	input wire sir_pkg::sir_pin_s pin_a,
	input wire sir_pkg::sir_pin_s pin_b,
	input wire logic [1:0] pol,
	output logic seen_a,
	output logic seen_b
);
	// Board pull-up holds a released line high
	assign seen_a = (pin_a.oe ? pin_a.out : 1'b1) == pol[1];
	assign seen_b = (pin_b.oe ? pin_b.out : 1'b1) == pol[0];
endmodule // sir_host_model

// ===== bench/sir_router_test.sv
`timescale 1ns/1ns
module sir_router_test;
	import sir_pkg::*;
	logic clk = 0, rst = 1, irq, sa, sb;
	logic [1:0] pol = '0;
	logic [7:0] rdata;
	sir_bus_req_s req = '0;
	sir_src_s src = '0;
	sir_pin_s pa, pb;
	int fail_count = 0, samples_checked = 0;
	sir_router dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
		.src_flags(src), .irq_pin_a(pa), .irq_pin_b(pb), .irq(irq));
	sir_host_model host (.pin_a(pa), .pin_b(pb), .pol(pol), .seen_a(sa),
		.seen_b(sb));
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		req <= '0;
		@(negedge clk);
		chk("rdata", rdata, e);
		@(posedge clk);
	endtask
	// Holds the sources, then checks every pin and the host view at once
	task automatic pins(logic [7:0] s, logic [7:0] e);
		req <= '0;
		src <= s;
		@(posedge clk);
		// Pins settle after the edge that registers them
		@(negedge clk);
		chk("pins", {pa.out, pa.oe, pb.out, pb.oe, irq, sa, sb, 1'b0}, e);
		@(posedge clk);
	endtask
	task automatic report_and_stop();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial forever #20 clk = ~clk;
	initial begin
		#20000;
		fail_count++;
		report_and_stop();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 8; i++) begin
			rd((i < 4 ? 8'h28 : 8'h3c) + i[7:0], 8'h00);
		end
		pins(8'hff, 8'hf0);
		rd(SIR_OFS_IRQ_SOURCE, 8'h00);
		wr(SIR_OFS_SOURCE_ROUTE, 8'h0f);
		rd(SIR_OFS_SOURCE_ROUTE, 8'h0f);
		for (int i = 0; i < 8; i++) begin
			wr(SIR_OFS_SOURCE_ENABLE, 8'h01 << i);
			pins(8'h01 << i, i < 4 ? 8'h74 : 8'hd2);
			rd(SIR_OFS_IRQ_SOURCE, 8'h01 << i);
			pins(8'h00, 8'hf0);
		end
		wr(SIR_OFS_SOURCE_ENABLE, 8'hff);
		rd(SIR_OFS_SOURCE_ENABLE, 8'hff);
		pins(8'h81, 8'h56);
		pins(8'h01, 8'h74);
		wr(SIR_OFS_PIN_CONFIG, 8'hff);
		pol <= 2'b11;
		rd(SIR_OFS_PIN_CONFIG, 8'h33);
		pins(8'h81, 8'ha6);
		pins(8'h00, 8'h50);
		wr(SIR_OFS_PIN_CONFIG, 8'h00);
		pol <= 2'b00;
		rd(SIR_OFS_IRQ_STATUS, 8'hff);
		wr(SIR_OFS_IRQ_STATUS, 8'hff);
		rd(SIR_OFS_IRQ_STATUS, 8'h00);
		wr(SIR_OFS_IRQ_MASK, 8'h80);
		pins(8'h80, 8'hda);
		pins(8'h00, 8'hf8);
		wr(SIR_OFS_IRQ_STATUS, 8'h80);
		pins(8'h40, 8'hd2);
		rd(SIR_OFS_IRQ_STATUS, 8'h40);
		wr(SIR_OFS_IRQ_MODE, 8'h01);
		pins(8'hff, 8'hf0);
		rd(SIR_OFS_IRQ_SOURCE, 8'h00);
		wr(SIR_OFS_IRQ_SOURCE, 8'hff);
		rd(SIR_OFS_IRQ_SOURCE, 8'h00);
		report_and_stop();
	end
endmodule // sir_router_test
